// ==== hdl/eip_regs.svh ====
// Constants of the event interrupt pulser: timing counts and status field layout.
// Assumes a 100 MHz mclk; included by the package and the design modules.
`ifndef EIP_REGS_SVH
`define EIP_REGS_SVH

`define EIP_CLK_MHZ 100
`define EIP_PULSE_US 100
`define EIP_GAP_US 100
`define EIP_CFG_FLT_US 7
`define EIP_PULSE_CYC (`EIP_PULSE_US * `EIP_CLK_MHZ)
`define EIP_GAP_CYC (`EIP_GAP_US * `EIP_CLK_MHZ)
`define EIP_CFG_FLT_CYC (`EIP_CFG_FLT_US * `EIP_CLK_MHZ)
`define EIP_CNT_W 16
`define EIP_WAKE_W 8
`define EIP_FAIL_W 16
`define EIP_CLASS_WAKE 1'h0
`define EIP_CLASS_GLOBAL 1'h1
// Bit positions inside the failure status vector.
`define EIP_FB_SUPPLY_UV 0
`define EIP_FB_WATCHDOG 1
`define EIP_FB_SUPPLY_SHORT 2
`define EIP_FB_THERMAL_TWO 3
`define EIP_FB_FAIL_OUT 4
`define EIP_FB_POWER_ON 5
`define EIP_FB_DEV_STAT_LO 6
`define EIP_FB_DEV_STAT_HI 7
// Failures that may raise an interrupt: bits 15..8 only.
`define EIP_FAIL_IRQ_MASK 16'hff00

`endif

// ==== hdl/eip_pkg.sv ====
// Types shared by the event interrupt pulser modules.
// Assumes eip_regs.svh on the include path.
`include "eip_regs.svh"

package eip_pkg;

   typedef enum logic [4:0] {
      EIP_MODE_INIT = 5'h01,
      EIP_MODE_NORMAL = 5'h02,
      EIP_MODE_STOP = 5'h04,
      EIP_MODE_SLEEP = 5'h08,
      EIP_MODE_FAILSAFE = 5'h10
   } eip_mode_e;

   typedef enum logic [2:0] {
      EIP_ST_IDLE = 3'h1,
      EIP_ST_PULSE = 3'h2,
      EIP_ST_GAP = 3'h4
   } eip_fsm_e;

   typedef struct packed {
      logic [`EIP_WAKE_W-1:0] wake_first;
      logic [`EIP_WAKE_W-1:0] wake_second;
      logic [`EIP_FAIL_W-1:0] fail;
   } eip_stat_s;

   typedef struct packed {
      eip_fsm_e fsm;
      logic [`EIP_CNT_W-1:0] cnt;
      eip_stat_s pend;
      logic stop_req;
      eip_stat_s status;
      logic irq_n;
      logic oe;
   } eip_top_s;

   typedef struct packed {
      logic s1;
      logic s2;
      logic cand;
      logic [`EIP_CNT_W-1:0] cnt;
      logic level;
   } eip_flt_s;

endpackage

// ==== hdl/eip_pin_filter.sv ====
// Configuration select filter: synchronises the interrupt pin and accepts a level
// only after it has stood still for the filter time. Assumes an asynchronous pin.
`timescale 1ns/1ps
`include "eip_regs.svh"

module eip_pin_filter import eip_pkg::*; (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic pin_in,
   input wire logic enable,
   output logic level
);

   eip_flt_s st_ff;
   eip_flt_s nxt_st;

   // Only the second stage is looked at; the first one may be metastable.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = pin_in;
      nxt_st.s2 = st_ff.s1;
      if (enable) begin
         if (st_ff.s2 != st_ff.cand) begin
            nxt_st.cand = st_ff.s2;
            nxt_st.cnt = `EIP_CNT_W'(`EIP_CFG_FLT_CYC - 1); // [R12]
         end else if (st_ff.cnt != '0) begin
            nxt_st.cnt = st_ff.cnt - `EIP_CNT_W'(1);
         end else begin
            nxt_st.level = st_ff.cand; // [R12]
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st_ff <= '0;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   assign level = st_ff.level;

   // A new level is taken only once the candidate has been steady for the full count.
   chk_filter_settle: assert property (@(posedge mclk) disable iff (reset) // [R12]
      (clk_en && enable && st_ff.level != st_ff.cand && st_ff.cnt != '0
       && st_ff.s2 == st_ff.cand) |=> $stable(st_ff.level))
      else $error("config level taken before filter time");

endmodule

// ==== hdl/eip_pulser.sv ====
// Event interrupt pulser: collects wake and failure events, drives the active-low
// interrupt line as timed pulses and keeps the host-visible status flags.
// Assumes event inputs are one-cycle pulses on mclk and clears come from the SPI logic.
//
// How it works
// [R1] In normal and stop mode each interrupt is a low pulse of the pulse time, then released.
// [R2] After each pulse the line stays high for at least the minimum gap time.
// [R3] The block only reads the operating mode and has no way to change it.
// [R4] A class select input of 0 picks wake interrupts and 1 picks global ones.
// [R5] A wake event raises an interrupt only when its source is enabled for wake.
// [R6] Global class adds failure interrupts; pin level changes never interrupt.
// [R7] Undervoltage, watchdog, short, thermal two, fail output, power-on and device bits never interrupt.
// [R8] Commanding stop mode with wake status still set raises one more pulse.
// [R9] Pending flags are copied into the status outputs at the falling edge of a pulse.
// [R10] Status flags stay set until the host clears them, and the host must clear them.
// [R11] The host may read a cleared register again to confirm the event is gone.
// [R12] In init mode the line is an input whose filtered level selects the configuration.
// [R13] A condition during a pulse or gap is held and pulsed once the gap has elapsed.
`timescale 1ns/1ps
`include "eip_regs.svh"

module eip_pulser import eip_pkg::*; #(
   parameter int unsigned PULSE_CYC = `EIP_PULSE_CYC,
   parameter int unsigned GAP_CYC = `EIP_GAP_CYC
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clk_en,
   input wire eip_mode_e mode,
   input wire logic int_class_select,
   input wire eip_stat_s event_in,
   input wire eip_stat_s wake_src_en,
   input wire logic stop_entry_cmd,
   input wire eip_stat_s status_clr,
   input wire logic irq_in,
   output logic irq_out_n,
   output logic irq_oe,
   output eip_stat_s status,
   output logic hw_config_sel
);

   eip_top_s st_ff;
   eip_top_s nxt_st;
   eip_stat_s ev;
   eip_stat_s kept;
   logic active;
   logic irq_req;
   logic wake_set;

   // Events are qualified first; only wake sources that are enabled count.
   always_comb begin
      ev.wake_first = event_in.wake_first & wake_src_en.wake_first; // [R5]
      ev.wake_second = event_in.wake_second & wake_src_en.wake_second; // [R5]
      ev.fail = event_in.fail;
      active = (mode == EIP_MODE_NORMAL) || (mode == EIP_MODE_STOP); // [R1]
      wake_set = (|st_ff.status.wake_first) || (|st_ff.status.wake_second);
      // Excluded failures are stored but masked out of the request. [R7]
      irq_req = (|st_ff.pend.wake_first) || (|st_ff.pend.wake_second) || st_ff.stop_req
         || (int_class_select == `EIP_CLASS_GLOBAL
             && (|(st_ff.pend.fail & `EIP_FAIL_IRQ_MASK))); // [R4] [R6]
      kept = eip_stat_s'(st_ff.status & ~status_clr); // [R10]
   end

   // Pulse sequencer. Mode is never driven from here, so no interrupt changes it. [R3]
   always_comb begin
      nxt_st = st_ff;
      nxt_st.pend = eip_stat_s'(st_ff.pend | ev); // [R13]
      nxt_st.status = kept;
      nxt_st.oe = (mode != EIP_MODE_INIT); // [R12]
      if (stop_entry_cmd && wake_set) begin
         nxt_st.stop_req = 1'h1; // [R8]
      end
      case (st_ff.fsm)
         EIP_ST_IDLE: begin
            nxt_st.irq_n = 1'h1;
            if (active && irq_req) begin
               nxt_st.fsm = EIP_ST_PULSE;
               nxt_st.cnt = `EIP_CNT_W'(PULSE_CYC - 1); // [R1]
               nxt_st.irq_n = 1'h0;
               // Capture and clear share this edge; a set flag beats a clear. [R9] [R10]
               nxt_st.status = eip_stat_s'(kept | st_ff.pend);
               nxt_st.pend = ev;
               nxt_st.stop_req = stop_entry_cmd && wake_set;
            end
         end
         EIP_ST_PULSE: begin
            if (st_ff.cnt == '0 || !active) begin
               // Leaving normal or stop mode cuts the pulse but still keeps the gap.
               nxt_st.fsm = EIP_ST_GAP;
               nxt_st.cnt = `EIP_CNT_W'(GAP_CYC - 1); // [R2]
               nxt_st.irq_n = 1'h1; // [R1]
            end else begin
               nxt_st.cnt = st_ff.cnt - `EIP_CNT_W'(1);
            end
         end
         EIP_ST_GAP: begin
            if (st_ff.cnt == '0) begin
               nxt_st.fsm = EIP_ST_IDLE; // [R2]
            end else begin
               nxt_st.cnt = st_ff.cnt - `EIP_CNT_W'(1);
            end
         end
         default: begin
            nxt_st.fsm = EIP_ST_IDLE;
            nxt_st.irq_n = 1'h1;
         end
      endcase
   end

   // State register; clk_en low freezes everything including the timers.
   always_ff @(posedge mclk) begin
      if (reset) begin
         st_ff <= '{fsm: EIP_ST_IDLE, irq_n: 1'h1, default: '0};
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   assign irq_out_n = st_ff.irq_n;
   assign irq_oe = st_ff.oe;
   assign status = st_ff.status;

   // The filter is enabled straight from the mode while irq_oe is registered, so its first samples in init mode still carry the driven level.
   eip_pin_filter u_cfg_filter (
      .mclk(mclk),
      .reset(reset),
      .clk_en(clk_en),
      .pin_in(irq_in),
      .enable(mode == EIP_MODE_INIT),
      .level(hw_config_sel)
   );

   // Helper counters of enabled cycles spent low and high, for the timing checks.
   logic [`EIP_CNT_W-1:0] low_cnt_ff;
   logic [`EIP_CNT_W-1:0] high_cnt_ff;
   logic seen_pulse_ff;
   always_ff @(posedge mclk) begin
      if (reset) begin
         low_cnt_ff <= '0;
         high_cnt_ff <= '0;
         seen_pulse_ff <= 1'h0;
      end else if (clk_en) begin
         low_cnt_ff <= st_ff.irq_n ? '0 : low_cnt_ff + `EIP_CNT_W'(1);
         if (!st_ff.irq_n) begin
            high_cnt_ff <= '0;
         end else if (high_cnt_ff != '1) begin
            // Saturates, so a long idle stretch never wraps into a false short gap.
            high_cnt_ff <= high_cnt_ff + `EIP_CNT_W'(1);
         end
         seen_pulse_ff <= seen_pulse_ff | ~st_ff.irq_n;
      end
   end

   // Status expected after a capture; kept as a signal so the check can look back at it.
   eip_stat_s capture_ref;
   assign capture_ref = eip_stat_s'((st_ff.status & ~status_clr) | st_ff.pend);

   sequence seq_pulse_start;
      clk_en && st_ff.fsm == EIP_ST_IDLE && active && irq_req;
   endsequence

   chk_pulse_len: assert property (@(posedge mclk) // [R1]
      disable iff (reset || !active)
      $rose(irq_out_n) |-> low_cnt_ff == `EIP_CNT_W'(PULSE_CYC))
      else $error("interrupt pulse width wrong");

   chk_gap_min: assert property (@(posedge mclk) disable iff (reset) // [R2]
      ($fell(irq_out_n) && seen_pulse_ff) |-> high_cnt_ff >= `EIP_CNT_W'(GAP_CYC))
      else $error("high gap between pulses too short");

   chk_fall_active: assert property (@(posedge mclk) disable iff (reset) // [R1]
      $fell(irq_out_n) |-> $past(active))
      else $error("pulse started outside normal or stop mode");

   chk_class_wake: assert property (@(posedge mclk) disable iff (reset) // [R4]
      (clk_en && st_ff.fsm == EIP_ST_IDLE && int_class_select == `EIP_CLASS_WAKE
       && st_ff.pend.wake_first == '0 && st_ff.pend.wake_second == '0 && !st_ff.stop_req)
      |=> irq_out_n)
      else $error("failure raised interrupt in wake class");

   chk_excluded_fail: assert property (@(posedge mclk) disable iff (reset) // [R7]
      (clk_en && st_ff.fsm == EIP_ST_IDLE && st_ff.pend.wake_first == '0
       && st_ff.pend.wake_second == '0 && !st_ff.stop_req
       && (st_ff.pend.fail & `EIP_FAIL_IRQ_MASK) == '0) |=> irq_out_n)
      else $error("excluded failure raised interrupt");

   chk_wake_masked: assert property (@(posedge mclk) disable iff (reset) // [R5]
      (clk_en && st_ff.fsm != EIP_ST_IDLE && st_ff.pend.wake_first == '0
       && (event_in.wake_first & wake_src_en.wake_first) == '0)
      |=> st_ff.pend.wake_first == '0)
      else $error("disabled wake source became pending");

   chk_status_capture: assert property (@(posedge mclk) disable iff (reset) // [R9]
      seq_pulse_start |=> !irq_out_n && status == $past(capture_ref))
      else $error("status not captured at pulse start");

   chk_status_hold: assert property (@(posedge mclk) disable iff (reset) // [R10]
      (clk_en && status_clr == '0) |=> (status & $past(status)) == $past(status))
      else $error("status flag lost without a clear");

   chk_stop_entry: assert property (@(posedge mclk) disable iff (reset) // [R8]
      (clk_en && stop_entry_cmd && wake_set) |=> st_ff.stop_req || !irq_out_n)
      else $error("stop entry with wake status raised no request");

   chk_hold_pending: assert property (@(posedge mclk) disable iff (reset) // [R13]
      (clk_en && st_ff.fsm != EIP_ST_IDLE && st_ff.stop_req) |=> st_ff.stop_req)
      else $error("pending request dropped during pulse or gap");

   chk_init_release: assert property (@(posedge mclk) disable iff (reset) // [R12]
      (clk_en && mode == EIP_MODE_INIT) |=> !irq_oe)
      else $error("interrupt pin driven in init mode");

   chk_oe_drive: assert property (@(posedge mclk) disable iff (reset) // [R12]
      (clk_en && mode != EIP_MODE_INIT) |=> irq_oe)
      else $error("interrupt pin not driven outside init mode");

   chk_idle_quiet: assert property (@(posedge mclk) disable iff (reset) // [R1]
      (clk_en && st_ff.fsm == EIP_ST_IDLE && !active) |=> irq_out_n)
      else $error("interrupt line pulled low while inactive");

   // Outside a capture edge a clear must take every flag it names.
   chk_clear_takes: assert property (@(posedge mclk) disable iff (reset) // [R10]
      (clk_en && !(st_ff.fsm == EIP_ST_IDLE && active && irq_req) && status_clr != '0)
      |=> (status & $past(status_clr)) == '0)
      else $error("status flag survived its clear");

endmodule

// ==== test/eip_host_model.sv ====
// Host side of the interrupt pin: resolves the shared wire from the block's drive
// and the board's configuration strap. Assumes the strap level is set by the bench.
`timescale 1ns/1ps

module eip_host_model (
   input wire logic irq_out_n,
   input wire logic irq_oe,
   input wire logic cfg_level,
   output logic irq_in
);
   // The strap only wins while the block has let go of the pin.
   assign irq_in = irq_oe ? irq_out_n : cfg_level;
endmodule

// ==== test/tb_event_interrupt_pulser.sv ====
// Self-checking bench for the event interrupt pulser with short pulse and gap counts.
// Assumes eip_regs.svh on the include path and the package compiled first.
`timescale 1ns/1ps

module tb_event_interrupt_pulser;
   import eip_pkg::*;
   typedef struct packed {logic cls; logic [31:0] ev; logic [31:0] en; logic hit;} eip_row_s;
   logic mclk = 1'h0;
   logic reset = 1'h1;
   eip_mode_e mode = EIP_MODE_NORMAL;
   logic cls = 1'h0;
   logic stop_cmd = 1'h0;
   logic cfg = 1'h0;
   logic ce = 1'h1;
   logic [31:0] ev = 32'h0;
   logic [31:0] en = 32'hffff_0000;
   logic [31:0] clr = 32'h0;
   logic irq_out_n, irq_oe, hw_config_sel, irq_in, hit;
   eip_stat_s status;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   int w, g;
   eip_row_s rows [6] = '{
      '{1'h0, 32'h0100_0000, 32'hffff_0000, 1'h1}, '{1'h0, 32'h0080_0000, 32'hffff_0000, 1'h1},
      '{1'h1, 32'h0000_0100, 32'hffff_0000, 1'h1}, '{1'h1, 32'h0000_8000, 32'hffff_0000, 1'h1},
      '{1'h0, 32'h0200_0000, 32'hfdff_0000, 1'h0}, '{1'h0, 32'h0000_0100, 32'hffff_0000, 1'h0}};

   // Short counts keep the run brief; every width below is derived from 8.
   eip_pulser #(.PULSE_CYC(8), .GAP_CYC(8)) eip_pulser_i (.mclk(mclk), .reset(reset),
      .clk_en(ce), .mode(mode), .int_class_select(cls), .event_in(eip_stat_s'(ev)),
      .wake_src_en(eip_stat_s'(en)), .stop_entry_cmd(stop_cmd), .status_clr(eip_stat_s'(clr)),
      .irq_in(irq_in), .irq_out_n(irq_out_n), .irq_oe(irq_oe), .status(status),
      .hw_config_sel(hw_config_sel));
   eip_host_model eip_host_model_i (.irq_out_n(irq_out_n), .irq_oe(irq_oe), .cfg_level(cfg),
      .irq_in(irq_in));

   // Clock of 100 MHz.
   always #5 mclk = ~mclk;

   // Cuts a hang short; the whole run needs about 2800 cycles.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Waits a bounded time for a low pulse and counts its low cycles at falling edges.
   task automatic measure();
      w = 0;
      // A pulse already low on entry is counted only from here; its earlier low cycles are not counted.
      for (int k = 0; k < 30 && irq_out_n !== 1'h0; k++) begin
         @(negedge mclk);
      end
      hit = (irq_out_n === 1'h0);
      while (irq_out_n === 1'h0 && w < 20) begin
         w++;
         @(negedge mclk);
      end
   endtask

   // One-cycle event, measure, then let the gap run out so the next test starts idle.
   task automatic fire(input eip_row_s r);
      cls = r.cls;
      en = r.en;
      ev = r.ev;
      @(posedge mclk);
      #1 ev = 32'h0;
      measure();
      repeat (12) @(posedge mclk);
      #1;
   endtask

   task automatic do_reset();
      reset = 1'h1;
      repeat (6) @(posedge mclk);
      #1 reset = 1'h0;
      @(negedge mclk);
      check("irq_out_n", irq_out_n, 1'h1);
      check("status", status, 32'h0);
      check("hw_config_sel", hw_config_sel, 1'h0);
      @(posedge mclk);
      #1;
   endtask

   initial begin
      do_reset();
      // Ordinary cases: every pulsing row is checked for width and captured status.
      foreach (rows[i]) begin
         fire(rows[i]);
         check("pulse", hit, rows[i].hit);
         if (rows[i].hit) begin
            check("width", w, 8);
            check("status", status, rows[i].ev);
            clr = 32'hffff_ffff;
            @(posedge mclk);
            #1 clr = 32'h0;
            check("cleared", status, 32'h0);
            @(posedge mclk);
            #1;
            check("cleared again", status, 32'h0);
         end
      end
      // A second reset drops what the refused rows left pending.
      do_reset();
      for (int b = 0; b < 8; b++) begin
         fire('{1'h1, 32'h1 << b, 32'hffff_0000, 1'h0});
         check("masked fail", hit, 1'h0);
      end
      // Held while sleeping, pulsed once normal mode returns.
      mode = EIP_MODE_SLEEP;
      fire('{1'h0, 32'h0100_0000, 32'hffff_0000, 1'h0});
      check("sleep pulse", hit, 1'h0);
      mode = EIP_MODE_NORMAL;
      measure();
      check("held pulse", hit, 1'h1);
      // The masked failures of the loop above were stored and are captured here.
      check("held status", status, 32'h0100_00ff);
      repeat (12) @(posedge mclk);
      #1 mode = EIP_MODE_STOP;
      fire('{1'h0, 32'h0004_0000, 32'hffff_0000, 1'h1});
      check("stop width", w, 8);
      check("status held", status, 32'h0104_00ff);
      // Second event inside the pulse: new pulse only after the full gap.
      ev = 32'h0100_0000;
      @(posedge mclk);
      #1 ev = 32'h0;
      repeat (4) @(posedge mclk);
      #1 ev = 32'h0008_0000;
      @(posedge mclk);
      #1 ev = 32'h0;
      measure();
      g = 0;
      while (irq_out_n === 1'h1 && g < 40) begin
         g++;
         @(negedge mclk);
      end
      check("gap", g >= 9, 1'h1);
      measure();
      check("second pulse", w, 8);
      repeat (12) @(posedge mclk);
      #1 stop_cmd = 1'h1;
      @(posedge mclk);
      // A frozen clock enable holds the stop request without acting on it.
      #1 stop_cmd = 1'h0;
      ce = 1'h0;
      repeat (5) @(posedge mclk);
      #1;
      check("frozen", irq_out_n, 1'h1);
      ce = 1'h1;
      measure();
      check("stop entry", hit, 1'h1);
      check("stop entry width", w, 8);
      // Init mode: pin released and the strapped level adopted after the filter.
      @(posedge mclk);
      #1 mode = EIP_MODE_INIT;
      cfg = 1'h1;
      repeat (720) @(posedge mclk);
      #1;
      check("irq_oe", irq_oe, 1'h0);
      check("hw_config_sel", hw_config_sel, 1'h1);
      // A strap change shorter than the filter time is ignored; a longer one is taken.
      cfg = 1'h0;
      repeat (600) @(posedge mclk);
      #1 cfg = 1'h1;
      repeat (10) @(posedge mclk);
      #1;
      check("short strap", hw_config_sel, 1'h1);
      cfg = 1'h0;
      repeat (720) @(posedge mclk);
      #1;
      check("long strap", hw_config_sel, 1'h0);
      // Back in normal mode the pin is driven high, yet the low strap level is kept.
      mode = EIP_MODE_NORMAL;
      repeat (3) @(posedge mclk);
      #1;
      check("irq_oe", irq_oe, 1'h1);
      check("config kept", hw_config_sel, 1'h0);
      complete_run();
   end
endmodule
